// >>> rtl/isdo_output_path.sv
// Sensor data output path: formatter, sequencer, serializer and APB control
`timescale 1ns/1ps
module isdo_output_path #(
    parameter int          FRAME_OVH  = isdo_pkg::FRAME_OVH_CYCLES,
    parameter int          ROW_OVH    = isdo_pkg::ROW_OVH_CYCLES,
    parameter logic [9:0]  CODE_FS    = 10'h2AA,
    parameter logic [9:0]  CODE_LS    = 10'h0AA,
    parameter logic [9:0]  CODE_LE    = 10'h12A,
    parameter logic [9:0]  CODE_FE    = 10'h32A,
    parameter logic [9:0]  CODE_DATA  = 10'h035,
    parameter logic [9:0]  CODE_IDLE  = 10'h3A6,
    parameter logic [9:0]  CODE_TRAIN = 10'h3A6,
    parameter logic [9:0]  CRC_POLY   = 10'h233,
    parameter logic [9:0]  CRC_INIT   = 10'h3FF
) (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Converter samples, eight columns, same clock domain
    input  wire logic [isdo_pkg::NUM_ADC-1:0][9:0] adc_data,
    output logic [11:0]      col_addr,
    // Pins from outside the clock domain
    input  wire logic        link_clk,
    input  wire logic        trigger,
    // Serial lanes
    output logic [isdo_pkg::NUM_CH-1:0] lane_data,
    output logic             lane_sync,
    output logic             lane_clk,
    // Parallel variant
    output logic [9:0]       par_data,
    output logic             frame_valid,
    output logic             line_valid,
    // Clocking control
    output logic             pll_enable
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [9:0] fit(input logic [9:0] w, input logic m10);
        fit = m10 ? w : {2'h0, w[9:2]};
    endfunction : fit

    function automatic logic [9:0] crc_step(input logic [9:0] c, input logic [9:0] d);
        logic [9:0] r;
        logic       fb;
        r = c;
        for (int i = 0; i < 10; i++)
        begin
            fb = r[9] ^ d[i];
            r  = {r[8:0], 1'b0} ^ (fb ? CRC_POLY : 10'h000);
        end
        crc_step = r;
    endfunction : crc_step

    // ------------------------------------------------------------------
    // APB registers
    // ------------------------------------------------------------------
    logic [31:0]          ctrl_reg;
    logic [31:0]          size_reg;
    logic [15:0]          frame_cnt;
    isdo_pkg::isdo_state_e state;
    isdo_pkg::isdo_ctrl_s ctrl;

    wire setup_ph = psel & ~penable & ~pready;
    wire hit_ctrl = paddr == isdo_pkg::ADDR_CTRL;
    wire hit_size = paddr == isdo_pkg::ADDR_SIZE;
    wire hit_stat = paddr == isdo_pkg::ADDR_STATUS;
    wire hit_any  = hit_ctrl | hit_size | hit_stat;
    wire busy     = state != isdo_pkg::ST_IDLE;
    wire [31:0] status_word = {frame_cnt, 15'h0, busy};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_reg : hit_size ? size_reg :
                         hit_stat ? status_word : 32'h0;
    // Writes land on the access edge the master samples pready high
    wire wr_fire  = psel & penable & pready & pwrite & ~pslverr;

    assign ctrl = '{hs_sel:   ctrl_reg[isdo_pkg::CTRL_HS_SEL],
                    parallel: ctrl_reg[isdo_pkg::CTRL_PAR],
                    sub:      ctrl_reg[isdo_pkg::CTRL_SUB_LO +: 2],
                    slave:    ctrl_reg[isdo_pkg::CTRL_SLAVE],
                    mode10:   ctrl_reg[isdo_pkg::CTRL_MODE10],
                    enable:   ctrl_reg[isdo_pkg::CTRL_EN]};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~hit_any;
            prdata  <= (setup_ph & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= isdo_pkg::CTRL_RESET;
            size_reg <= isdo_pkg::SIZE_RESET;
        end
        else if (wr_fire)
        begin
            if (hit_ctrl)
                ctrl_reg <= pwdata;
            if (hit_size)
                size_reg <= pwdata;
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [2:0] lclk_sync;
    logic [2:0] trig_sync;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lclk_sync <= 3'h0;
            trig_sync <= 3'h0;
        end
        else
        begin
            lclk_sync <= {lclk_sync[1:0], link_clk};
            trig_sync <= {trig_sync[1:0], trigger};
        end
    end
    // Both link clock edges carry a bit (double data rate)
    wire bit_tick  = lclk_sync[1] ^ lclk_sync[2];
    wire trig_rise = trig_sync[1] & ~trig_sync[2];

    // ------------------------------------------------------------------
    // Word timing
    // ------------------------------------------------------------------
    logic [3:0] bit_cnt;
    wire  [3:0] last_bit  = ctrl.parallel ? 4'(isdo_pkg::LAST_BIT_PAR) :
                            ctrl.mode10 ? 4'(isdo_pkg::LAST_BIT_10) :
                            4'(isdo_pkg::LAST_BIT_8);
    wire        word_tick = bit_tick & (bit_cnt >= last_bit);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    logic [isdo_pkg::CNT_W-1:0] ovh_cnt;
    logic [11:0] pix_cnt;
    logic [11:0] line_cnt;
    logic        trig_pend;
    logic        first_line;
    isdo_pkg::isdo_state_e next_state;

    wire [11:0] words_cfg = size_reg[isdo_pkg::SIZE_WORDS_LO +: isdo_pkg::SIZE_FIELD_W];
    wire [11:0] lines_cfg = size_reg[isdo_pkg::SIZE_LINES_LO +: isdo_pkg::SIZE_FIELD_W];
    // Subsampling halves the words of each line
    wire [11:0] words_eff = (ctrl.sub == isdo_pkg::SUB_NONE) ? words_cfg : words_cfg >> 1;
    wire        ovh_done  = (state == isdo_pkg::ST_FRAME_OVH) ?
                            (32'(ovh_cnt) >= FRAME_OVH - 1) :
                            (32'(ovh_cnt) >= ROW_OVH - 1);
    wire        start_ok  = ctrl.enable & (~ctrl.slave | trig_pend);
    wire        pix_last  = pix_cnt + 12'h1 >= words_eff;
    wire        line_last = line_cnt + 12'h1 >= lines_cfg;

    always_comb
    begin
        next_state = state;
        case (state)
            isdo_pkg::ST_IDLE:      if (start_ok) next_state = isdo_pkg::ST_FRAME_OVH;
            isdo_pkg::ST_FRAME_OVH: if (ovh_done) next_state = isdo_pkg::ST_ROW_OVH;
            isdo_pkg::ST_ROW_OVH:   if (ovh_done) next_state = isdo_pkg::ST_LS;
            isdo_pkg::ST_LS:        next_state = isdo_pkg::ST_PIX;
            isdo_pkg::ST_PIX:       if (pix_last) next_state = isdo_pkg::ST_LE;
            isdo_pkg::ST_LE:        next_state = isdo_pkg::ST_CRC;
            isdo_pkg::ST_CRC:       next_state = line_last ? isdo_pkg::ST_FE : isdo_pkg::ST_ROW_OVH;
            isdo_pkg::ST_FE:        next_state = isdo_pkg::ST_IDLE;
            default:                next_state = isdo_pkg::ST_IDLE;
        endcase
    end

    wire adv = word_tick & (next_state != state);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state      <= isdo_pkg::ST_IDLE;
            ovh_cnt    <= '0;
            trig_pend  <= 1'b0;
            frame_cnt  <= 16'h0;
        end
        else
        begin
            if (word_tick)
                state <= next_state;
            ovh_cnt <= adv ? '0 : (ovh_done ? ovh_cnt : ovh_cnt + 1'b1);
            // A trigger arriving while the frame starts is kept for the next one
            if (trig_rise)
                trig_pend <= 1'b1;
            else if (adv && state == isdo_pkg::ST_IDLE)
                trig_pend <= 1'b0;
            if (adv && state == isdo_pkg::ST_FE)
                frame_cnt <= frame_cnt + 16'h1;
        end
    end

    // ------------------------------------------------------------------
    // Pixel and column counters
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pix_cnt    <= 12'h0;
            line_cnt   <= 12'h0;
            col_addr   <= 12'h0;
            first_line <= 1'b0;
        end
        else if (word_tick)
        begin
            if (state == isdo_pkg::ST_PIX)
            begin
                pix_cnt <= pix_cnt + 12'h1;
                // R2S2 reads a pair of columns, then jumps over the next pair
                if (ctrl.sub == isdo_pkg::SUB_R1S1)
                    col_addr <= col_addr + 12'h2;
                else if (ctrl.sub == isdo_pkg::SUB_R2S2)
                    col_addr <= col_addr + (col_addr[0] ? 12'h3 : 12'h1);
                else
                    col_addr <= col_addr + 12'h1;
            end
            else
            begin
                pix_cnt  <= 12'h0;
                col_addr <= 12'h0;
            end
            if (state == isdo_pkg::ST_FRAME_OVH)
                first_line <= 1'b1;
            else if (state == isdo_pkg::ST_LS)
                first_line <= 1'b0;
            if (state == isdo_pkg::ST_IDLE)
                line_cnt <= 12'h0;
            else if (state == isdo_pkg::ST_CRC)
                line_cnt <= line_cnt + 12'h1;
        end
    end

    // ------------------------------------------------------------------
    // Formatter: interleave, CRC and sync codes
    // ------------------------------------------------------------------
    logic [isdo_pkg::NUM_CH-1:0][9:0] crc;
    logic [isdo_pkg::NUM_CH-1:0][9:0] pix_word;
    logic [isdo_pkg::NUM_CH-1:0][9:0] ch_word;
    wire  [9:0] sync_word;

    for (genvar c = 0; c < isdo_pkg::NUM_CH; c++)
    begin : g_ch
        // Even words from the first converter of the pair, odd from the second
        assign pix_word[c] = fit(pix_cnt[0] ? adc_data[2*c+1] : adc_data[2*c],
                                 ctrl.mode10);
        assign ch_word[c]  = (state == isdo_pkg::ST_PIX) ? pix_word[c] :
                             (state == isdo_pkg::ST_CRC) ? fit(crc[c], ctrl.mode10) :
                             fit(CODE_TRAIN, ctrl.mode10);

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                crc[c] <= CRC_INIT;
            else if (word_tick && state == isdo_pkg::ST_LS)
                crc[c] <= CRC_INIT;
            else if (word_tick && state == isdo_pkg::ST_PIX)
                crc[c] <= crc_step(crc[c], pix_word[c]);
        end
    end

    assign sync_word = fit((state == isdo_pkg::ST_LS)  ? (first_line ? CODE_FS : CODE_LS) :
                           (state == isdo_pkg::ST_PIX) ? CODE_DATA :
                           (state == isdo_pkg::ST_LE)  ? CODE_LE :
                           (state == isdo_pkg::ST_FE)  ? CODE_FE : CODE_IDLE,
                           ctrl.mode10);

    isdo_pkg::isdo_words_s words;
    assign words = '{sync: sync_word, ch3: ch_word[3], ch2: ch_word[2],
                     ch1: ch_word[1], ch0: ch_word[0]};

    // ------------------------------------------------------------------
    // Serializer and parallel multiplexer
    // ------------------------------------------------------------------
    // Bit rate is set by the link clock; the lane limits hold when it stays in range
    isdo_pkg::isdo_words_s shreg;
    logic [isdo_pkg::NUM_CH-1:0][9:0] pbuf;
    wire  [3:0] pnext = bit_cnt + 4'h1;
    wire        serial_on = ~ctrl.parallel;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_cnt   <= 4'h0;
            shreg     <= '0;
            pbuf      <= '0;
            lane_data <= '0;
            lane_sync <= 1'b0;
            par_data  <= 10'h0;
        end
        else if (bit_tick)
        begin
            bit_cnt <= word_tick ? 4'h0 : pnext;
            if (word_tick)
            begin
                shreg     <= words >> 1;
                pbuf      <= {words.ch3, words.ch2, words.ch1, words.ch0};
                lane_data <= {4{serial_on}} & {words.ch3[0], words.ch2[0],
                                               words.ch1[0], words.ch0[0]};
                lane_sync <= serial_on & words.sync[0];
                par_data  <= ctrl.parallel ? words.ch0 : 10'h0;
            end
            else
            begin
                shreg     <= shreg >> 1;
                lane_data <= {4{serial_on}} & {shreg.ch3[0], shreg.ch2[0],
                                               shreg.ch1[0], shreg.ch0[0]};
                lane_sync <= serial_on & shreg.sync[0];
                par_data  <= ctrl.parallel ? pbuf[pnext[1:0]] : 10'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lane_clk    <= 1'b0;
            frame_valid <= 1'b0;
            line_valid  <= 1'b0;
            pll_enable  <= 1'b0;
        end
        else
        begin
            // Clock lane toggles in the same cycle that data bits change
            lane_clk   <= serial_on & lclk_sync[1];
            pll_enable <= ~ctrl.hs_sel;
            if (word_tick)
            begin
                frame_valid <= ctrl.parallel & (state != isdo_pkg::ST_IDLE) &
                               (state != isdo_pkg::ST_FRAME_OVH);
                line_valid  <= ctrl.parallel & (state == isdo_pkg::ST_PIX);
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    frame_ovh_a: assert property ($rose(state == isdo_pkg::ST_ROW_OVH) &&
        $past(state) == isdo_pkg::ST_FRAME_OVH |-> 32'($past(ovh_cnt)) >= FRAME_OVH - 1)
        else $error("row overhead entered before frame overhead elapsed");
    row_ovh_a: assert property (state == isdo_pkg::ST_ROW_OVH ##1
        state == isdo_pkg::ST_LS |-> 32'($past(ovh_cnt)) >= ROW_OVH - 1)
        else $error("line started before row overhead elapsed");
    slave_start_a: assert property (ctrl.slave && !trig_pend &&
        state == isdo_pkg::ST_IDLE |=> state == isdo_pkg::ST_IDLE)
        else $error("slave sequencer started without trigger");
    master_start_a: assert property (ctrl.enable && !ctrl.slave &&
        state == isdo_pkg::ST_IDLE && word_tick |=> state == isdo_pkg::ST_FRAME_OVH)
        else $error("master sequencer did not start");
    crc_reset_a: assert property (word_tick && state == isdo_pkg::ST_LS
        |=> crc[0] == CRC_INIT)
        else $error("line CRC not restarted at line start");
    sync_code_a: assert property (word_tick && state == isdo_pkg::ST_LE &&
        !ctrl.parallel |=> lane_sync == (ctrl.mode10 ? CODE_LE[0] : CODE_LE[2]))
        else $error("line end code missing on sync lane");
    pll_ctrl_a: assert property (ctrl.hs_sel |=> !pll_enable)
        else $error("PLL left on with fast clock input");
    // Data lanes only refresh on a bit tick, so the quiet level is checked after one
    par_quiet_a: assert property (ctrl.parallel && bit_tick
        |=> lane_data == '0 && !lane_clk)
        else $error("serial lanes active in parallel variant");
    lv_in_frame_a: assert property (line_valid |-> frame_valid)
        else $error("line valid outside frame valid");
    word_len_a: assert property (word_tick && !ctrl.parallel |-> bit_cnt ==
        (ctrl.mode10 ? 4'(isdo_pkg::LAST_BIT_10) : 4'(isdo_pkg::LAST_BIT_8)))
        else $error("word length does not match output mode");

    frame_done_c: cover property (state == isdo_pkg::ST_FE ##1 state == isdo_pkg::ST_IDLE);
    slave_trig_c: cover property (ctrl.slave && trig_rise);
    par_line_c:   cover property ($rose(line_valid));
    crc_sent_c:   cover property (word_tick && state == isdo_pkg::ST_CRC);

endmodule : isdo_output_path

// >>> rtl/isdo_pkg.sv
// Shared constants, register map and carrier types of the sensor output path
package isdo_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_SIZE    = 8'h04;
    localparam logic [7:0]  ADDR_STATUS  = 8'h08;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0002;
    localparam logic [31:0] SIZE_RESET   = 32'h04B0_01E0;

    // CTRL fields
    localparam int CTRL_EN      = 0;
    localparam int CTRL_MODE10  = 1;
    localparam int CTRL_SLAVE   = 2;
    localparam int CTRL_SUB_LO  = 3;
    localparam int CTRL_PAR     = 5;
    localparam int CTRL_HS_SEL  = 6;
    // SIZE fields
    localparam int SIZE_WORDS_LO = 0;
    localparam int SIZE_LINES_LO = 16;
    localparam int SIZE_FIELD_W  = 12;
    // STATUS fields
    localparam int STAT_BUSY     = 0;
    localparam int STAT_FRAME_LO = 16;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS    = 8000;
    localparam int FRAME_OVH_NS     = 45000;
    localparam int ROW_OVH_PS       = 1100000;
    localparam int FRAME_OVH_CYCLES = (FRAME_OVH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ROW_OVH_CYCLES   = (ROW_OVH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W            = 16;

    // Word sizes and lanes
    localparam int WORD_W        = 10;
    localparam int LAST_BIT_10   = 9;
    localparam int LAST_BIT_8    = 7;
    localparam int LAST_BIT_PAR  = 3;
    localparam int NUM_CH        = 4;
    localparam int NUM_ADC       = 8;

    // Subsampling modes
    localparam logic [1:0] SUB_NONE = 2'h0;
    localparam logic [1:0] SUB_R1S1 = 2'h1;
    localparam logic [1:0] SUB_R2S2 = 2'h2;

    typedef enum { ST_IDLE, ST_FRAME_OVH, ST_ROW_OVH, ST_LS, ST_PIX,
                   ST_LE, ST_CRC, ST_FE } isdo_state_e;

    typedef struct packed {
        logic       hs_sel;
        logic       parallel;
        logic [1:0] sub;
        logic       slave;
        logic       mode10;
        logic       enable;
    } isdo_ctrl_s;

    typedef struct packed {
        logic [WORD_W-1:0] sync;
        logic [WORD_W-1:0] ch3;
        logic [WORD_W-1:0] ch2;
        logic [WORD_W-1:0] ch1;
        logic [WORD_W-1:0] ch0;
    } isdo_words_s;

endpackage : isdo_pkg

// >>> test/isdo_rx_model.sv
// Frame grabber model: deserialises sync and data lanes and checks each line
`timescale 1ns/1ps
module isdo_rx_model #(
    parameter logic [9:0] CODE_FS   = 10'h2AA,
    parameter logic [9:0] CODE_LS   = 10'h0AA,
    parameter logic [9:0] CODE_LE   = 10'h12A,
    parameter logic [9:0] CODE_FE   = 10'h32A,
    parameter logic [9:0] CODE_DATA = 10'h035,
    parameter logic [9:0] CRC_POLY  = 10'h233,
    parameter logic [9:0] CRC_INIT  = 10'h3FF
) (
    // Link side
    input  wire logic            link_clk,
    input  wire logic            presetn,
    input  wire logic [3:0]      lane_data,
    input  wire logic            lane_sync,
    input  wire logic [7:0][9:0] adc_data,
    // Results
    output int                   frames,
    output int                   lines,
    output int                   crc_errs,
    output int                   pix_errs,
    output logic [9:0]           first_red
);
    logic [9:0]      sr;
    logic [3:0][9:0] dr, crc;
    int              nbit;
    // Reset may be over before the first link edge, so start unlocked
    logic            locked = 1'b0, crc_due = 1'b0, first_pix = 1'b0;

    function automatic logic [9:0] crc_step(input logic [9:0] c, input logic [9:0] d);
        logic fb;
        for (int i = 0; i < 10; i++)
        begin
            fb = c[9] ^ d[i];
            c  = {c[8:0], 1'b0} ^ (fb ? CRC_POLY : 10'h000);
        end
        return c;
    endfunction : crc_step

    task automatic take_word();
        if (crc_due)
            for (int c = 0; c < 4; c++)
                if (dr[c] !== crc[c])
                    crc_errs++;
        crc_due = 1'b0;
        if (sr === CODE_FS || sr === CODE_LS)
        begin
            lines++;
            crc       = {4{CRC_INIT}};
            first_pix = (sr === CODE_FS);
        end
        else if (sr === CODE_DATA)
        begin
            if (first_pix)
                first_red = dr[0];
            first_pix = 1'b0;
            for (int c = 0; c < 4; c++)
            begin
                if (dr[c] !== adc_data[2*c] && dr[c] !== adc_data[2*c+1])
                    pix_errs++;
                crc[c] = crc_step(crc[c], dr[c]);
            end
        end
        else if (sr === CODE_LE)
            crc_due = 1'b1;
        else if (sr === CODE_FE)
        begin
            frames++;
            locked = 1'b0;
        end
    endtask : take_word

    // Bits change a few system clocks after each link edge, so the next edge sees them settled
    always @(link_clk or negedge presetn)
    begin
        if (!presetn)
        begin
            {frames, lines, crc_errs, pix_errs, nbit} = '0;
            {locked, crc_due} = '0;
        end
        else
        begin
            sr = {lane_sync, sr[9:1]};
            for (int c = 0; c < 4; c++)
                dr[c] = {lane_data[c], dr[c][9:1]};
            nbit++;
            if (!locked && sr === CODE_FS)
            begin
                locked = 1'b1;
                nbit   = 10;
            end
            if (locked && nbit == 10)
            begin
                nbit = 0;
                take_word();
            end
        end
    end
endmodule : isdo_rx_model

// >>> test/test_image_sensor_data_output_path.sv
// Self-checking bench of the sensor output path
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))
module test_image_sensor_data_output_path;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic link_clk = 1'b0, trigger = 1'b0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [7:0][9:0] adc = {10'h3C8, 10'h2B7, 10'h1A6, 10'h095,
                            10'h384, 10'h273, 10'h162, 10'h051};
    logic pready, pslverr, lane_sync, lane_clk, frame_valid, line_valid, pll_enable;
    logic [3:0]  lane_data;
    logic [9:0]  par_data, first_red;
    logic [11:0] col_addr;
    int frames, lines, crc_errs, pix_errs, clk_edges = 0, bad_count = 0, n_checks = 0;

    initial forever #4 pclk = ~pclk;
    initial forever #62.5 link_clk = ~link_clk;
    always @(lane_clk) clk_edges++;

    isdo_output_path #(.FRAME_OVH(20), .ROW_OVH(5)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .adc_data(adc),
        .col_addr(col_addr), .link_clk(link_clk), .trigger(trigger), .lane_data(lane_data),
        .lane_sync(lane_sync), .lane_clk(lane_clk), .par_data(par_data),
        .frame_valid(frame_valid), .line_valid(line_valid), .pll_enable(pll_enable));
    isdo_rx_model rx_u (.link_clk(link_clk), .presetn(presetn), .lane_data(lane_data),
        .lane_sync(lane_sync), .adc_data(adc), .frames(frames), .lines(lines),
        .crc_errs(crc_errs), .pix_errs(pix_errs), .first_red(first_red));

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check

    task automatic tally_and_finish();
        if (bad_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    task automatic stall();
        bad_count++;
        tally_and_finish();
    endtask : stall

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        // Start on a fresh edge so a back-to-back call never drives psel twice at once
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 50)
            stall();
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_busy(input logic v);
        int i;
        for (i = 0; i < 2000; i++)
        begin
            apb(1'b0, isdo_pkg::ADDR_STATUS, 32'h0);
            if (r[isdo_pkg::STAT_BUSY] === v)
                break;
        end
        if (i == 2000)
            stall();
    endtask : wait_busy

    task automatic s_regs();
        apb(1'b0, isdo_pkg::ADDR_CTRL, 32'h0);
        `CHK(r, isdo_pkg::CTRL_RESET);
        apb(1'b0, isdo_pkg::ADDR_SIZE, 32'h0);
        `CHK(r, isdo_pkg::SIZE_RESET);
        `CHK(pll_enable, 1'b1);
        apb(1'b1, isdo_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, isdo_pkg::ADDR_STATUS, 32'h0);
        `CHK(r, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        `CHK(err, 1'b1);
    endtask : s_regs

    // Two lines of four words, decoded and CRC-checked by the grabber model
    task automatic s_serial();
        int i;
        apb(1'b1, isdo_pkg::ADDR_SIZE, 32'h0002_0004);
        apb(1'b1, isdo_pkg::ADDR_CTRL, 32'h0000_0003);
        for (i = 0; i < 40000 && frames == 0; i++)
            @(posedge pclk);
        if (i == 40000)
            stall();
        `CHK(frames, 1);
        `CHK(lines, 2);
        `CHK(crc_errs, 0);
        `CHK(pix_errs, 0);
        `CHK(first_red, adc[0]);
        `CHK(clk_edges > 40, 1'b1);
        apb(1'b1, isdo_pkg::ADDR_CTRL, 32'h0000_0002);
        wait_busy(1'b0);
        `CHK(r[31:16] !== 16'h0000, 1'b1);
    endtask : s_serial

    task automatic s_slave();
        apb(1'b1, isdo_pkg::ADDR_CTRL, 32'h0000_0007);
        repeat (100) @(posedge pclk);
        apb(1'b0, isdo_pkg::ADDR_STATUS, 32'h0);
        `CHK(r[0], 1'b0);
        trigger <= 1'b1;
        repeat (10) @(posedge pclk);
        trigger <= 1'b0;
        wait_busy(1'b1);
        `CHK(r[0], 1'b1);
        apb(1'b1, isdo_pkg::ADDR_CTRL, 32'h0000_0006);
        wait_busy(1'b0);
    endtask : s_slave

    task automatic s_par();
        int i;
        // Parallel, fast clock input, read-1-skip-1
        apb(1'b1, isdo_pkg::ADDR_CTRL, 32'h0000_006B);
        repeat (3) @(posedge pclk);
        `CHK(pll_enable, 1'b0);
        for (i = 0; i < 40000 && frame_valid !== 1'b1; i++)
            @(posedge pclk);
        `CHK(frame_valid, 1'b1);
        `CHK(lane_clk, 1'b0);
        for (i = 0; i < 40000 && line_valid !== 1'b1; i++)
            @(posedge pclk);
        `CHK(line_valid, 1'b1);
        `CHK(par_data, adc[0]);
        `CHK(col_addr, 12'h2);
    endtask : s_par

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_regs();
        s_serial();
        s_slave();
        s_par();
        tally_and_finish();
    end
endmodule : test_image_sensor_data_output_path
